// File: logic/pso_pkg.sv
// Purpose: Shared constants, field layouts and types of the status output selector.
// Assumes: 32-bit APB data, 12-bit APB byte addresses, one aligned word per register.
// Notes:   Each loop's mode field holds the top five data bits of a serial word.
package pso_pkg;

  // Serial word layout: data bits R[19:0] above a two-bit address.
  localparam int unsigned WORD_W     = 22;
  localparam int unsigned ADDR_W     = 2;
  localparam int unsigned MODE_W     = 5;
  localparam int unsigned MODE_LSB   = 17;
  localparam int unsigned MODE_MSB   = 21;
  localparam logic [1:0]  ADDR_AUX   = 2'h0;
  localparam logic [1:0]  ADDR_MAIN  = 2'h2;

  // Indices of the pin inputs inside the synchroniser vector.
  localparam int unsigned IN_W       = 10;
  localparam int unsigned IN_SCLK    = 0;
  localparam int unsigned IN_SDATA   = 1;
  localparam int unsigned IN_LE      = 2;
  localparam int unsigned IN_MLOCK   = 3;
  localparam int unsigned IN_ALOCK   = 4;
  localparam int unsigned IN_MREF    = 5;
  localparam int unsigned IN_AREF    = 6;
  localparam int unsigned IN_MFB     = 7;
  localparam int unsigned IN_AFB     = 8;
  localparam int unsigned IN_CPBUSY  = 9;
  // Reset level of the synchroniser; load enable idles high, every other pin low.
  localparam logic [IN_W-1:0] IN_RST = 10'h004;

  // APB register byte offsets.
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_MODE   = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_MASK   = 12'h00c;
  localparam logic [11:0] OFS_WORD   = 12'h010;

  // Field positions and reset values.
  localparam int unsigned EV_W       = 4;
  localparam int unsigned EV_LOADED  = 0;
  localparam int unsigned EV_FAST_ON = 1;
  localparam int unsigned EV_FAST_OFF = 2;
  localparam int unsigned EV_LOCK_LOST = 3;
  localparam int unsigned CTRL_ACCEPT = 0;
  localparam int unsigned MODE_MAIN_LSB = 5;
  localparam int unsigned MODE_FUNC_LSB = 16;
  localparam logic        CTRL_RST   = 1'h1;
  localparam logic [3:0]  MASK_RST   = 4'h0;

  // One loop's mode bits, R19 down to R15.
  typedef struct packed {
    logic sel_hi;
    logic sel_lo;
    logic cp_tri;
    logic cp_4x;
    logic pd_pol;
  } pso_mode_t;

  localparam pso_mode_t MODE_RST = '0;

  // Status pin function, one-hot.
  typedef enum logic [11:0] {
    F_DIS      = 12'h001,
    F_LD_AUX   = 12'h002,
    F_LD_MAIN  = 12'h004,
    F_LD_BOTH  = 12'h008,
    F_REF_AUX  = 12'h010,
    F_REF_MAIN = 12'h020,
    F_FB_AUX   = 12'h040,
    F_FB_MAIN  = 12'h080,
    F_FAST     = 12'h100,
    F_RST_AUX  = 12'h200,
    F_RST_MAIN = 12'h400,
    F_RST_ALL  = 12'h800
  } pso_func_t;

endpackage

// File: logic/pso_sync.sv
// Purpose: Two-flip-flop synchroniser for a vector of independent levels.
// Assumes: Each bit is an unrelated level; no bus coherency is implied.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/100ps
module pso_sync #(
  parameter int unsigned  W   = 1,
  parameter logic [W-1:0] RST = '0 // Reset level of both stages, per bit.
) (
  input  wire logic         pclk,     // System clock.
  input  wire logic         presetn,  // Asynchronous reset, active low.
  input  wire logic [W-1:0] async_i,  // Levels from outside the clock domain.
  output logic      [W-1:0] sync_o    // Synchronised levels.
);

  logic [W-1:0] meta_r;

  // Both stages take the idle level under reset, so no false edge follows release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= RST;
      sync_o <= RST;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule // pso_sync

// File: logic/pso_top.sv
// Purpose: Status pin function decoder, counter reset and fast acquisition control,
//          with the three-wire serial loader and an APB register window.
// Assumes: Serial clock far slower than pclk; lock and divider inputs are levels.
// Notes:   Behaviour
// Behaviour
// - Lower bits pick disabled or lock detect.
// - One upper bit shows that loop's reference divider.
// - Aux lower set shows feedback divider instead.
// - Both upper, lowers clear: open-drain fast switch.
// - Aux reset pattern resets aux counters, hiz pump.
// - Main reset pattern resets main counters, hiz pump.
// - All set resets everything, both pumps hiz.
// - Lock detect pin released high while locked.
// - Combined lock needs both loops locked.
// - Fast acquisition when main gain high, pattern set.
// - Counters leave reset together, aligned.
// - Serial bit taken on serial clock rising edge.
// - Fast acquisition uses four times pump current.
// - Gain drop applied only between pump pulses.
// - Loader keeps working during power-down.
`timescale 1ns/100ps
module pso_top #(
  parameter int unsigned WORD_W = pso_pkg::WORD_W
) (
  input  wire logic        pclk,               // System clock, 100 MHz.
  input  wire logic        presetn,            // Asynchronous reset, active low.
  input  wire logic        psel,               // APB select.
  input  wire logic        penable,            // APB enable.
  input  wire logic        pwrite,             // APB direction, high for write.
  input  wire logic [11:0] paddr,              // APB byte address.
  input  wire logic [31:0] pwdata,             // APB write data.
  output logic      [31:0] prdata,             // APB read data.
  output logic             pready,             // APB ready.
  output logic             pslverr,            // APB error for unmapped address.
  output logic             irq_o,              // Level interrupt.
  input  wire logic        ser_clk_i,          // Serial clock from host.
  input  wire logic        ser_data_i,         // Serial data from host.
  input  wire logic        ser_le_i,           // Serial load enable from host.
  input  wire logic        main_lock_i,        // Main loop lock level.
  input  wire logic        aux_lock_i,         // Aux loop lock level.
  input  wire logic        main_ref_div_i,     // Main reference divider output.
  input  wire logic        aux_ref_div_i,      // Aux reference divider output.
  input  wire logic        main_fb_div_i,      // Main feedback divider output.
  input  wire logic        aux_fb_div_i,       // Aux feedback divider output.
  input  wire logic        main_cp_busy_i,     // Main charge pump pulse in progress.
  output logic             status_out_pin_o,   // Status pin output value.
  output logic             status_out_pin_oe,  // Status pin output enable.
  output logic             main_ref_cnt_rst_o, // Main reference counter reset.
  output logic             main_fb_cnt_rst_o,  // Main feedback counter reset.
  output logic             aux_ref_cnt_rst_o,  // Aux reference counter reset.
  output logic             aux_fb_cnt_rst_o,   // Aux feedback counter reset.
  output logic             main_cp_hiz_o,      // Main charge pump high impedance.
  output logic             aux_cp_hiz_o,       // Aux charge pump high impedance.
  output logic             main_cp_gain_4x_o,  // Main charge pump current times four.
  output logic             aux_cp_gain_4x_o,   // Aux charge pump current times four.
  output logic             main_pd_pol_o,      // Main phase detector polarity.
  output logic             aux_pd_pol_o,       // Aux phase detector polarity.
  output logic             fast_acq_o          // Fast acquisition active.
);

  logic [pso_pkg::IN_W-1:0] in_s;
  logic                     sclk_d_r;
  logic                     le_d_r;
  logic [WORD_W-1:0]        shift_r;
  logic [WORD_W-1:0]        word_r;
  pso_pkg::pso_mode_t       main_mode_r;
  pso_pkg::pso_mode_t       aux_mode_r;
  logic                     main_gain_r;
  logic                     aux_gain_r;
  logic                     fast_r;
  logic                     ld_ok_r;
  logic                     ctrl_accept_r;
  logic [pso_pkg::EV_W-1:0] status_r;
  logic [pso_pkg::EV_W-1:0] status_nxt;
  logic [pso_pkg::EV_W-1:0] mask_r;
  logic [31:0]              prdata_r;

  // Pins pass two flip-flops before any logic reads them.
  pso_sync #(.W (pso_pkg::IN_W), .RST (pso_pkg::IN_RST)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .async_i ({main_cp_busy_i, aux_fb_div_i, main_fb_div_i, aux_ref_div_i, main_ref_div_i,
               aux_lock_i, main_lock_i, ser_le_i, ser_data_i, ser_clk_i}),
    .sync_o  (in_s)
  );

  // Named views of the synchronised inputs and their edges.
  wire sclk_s   = in_s[pso_pkg::IN_SCLK];
  wire sdata_s  = in_s[pso_pkg::IN_SDATA];
  wire le_s     = in_s[pso_pkg::IN_LE];
  wire mlock_s  = in_s[pso_pkg::IN_MLOCK];
  wire alock_s  = in_s[pso_pkg::IN_ALOCK];
  wire cpbusy_s = in_s[pso_pkg::IN_CPBUSY];
  wire sclk_rise = sclk_s & ~sclk_d_r;
  wire le_rise   = le_s & ~le_d_r;
  wire shift_en  = sclk_rise & ~le_s;
  wire load_en   = le_rise & ctrl_accept_r;
  wire [1:0] word_addr = shift_r[pso_pkg::ADDR_W-1:0];
  wire [pso_pkg::MODE_W-1:0] word_mode = shift_r[pso_pkg::MODE_MSB:pso_pkg::MODE_LSB];

  // Edge detector history of serial clock and load enable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_d_r <= 1'b0;
      le_d_r   <= 1'b1; // Idle level of load enable, so reset fakes no load.
    end else begin
      sclk_d_r <= sclk_s;
      le_d_r   <= le_s;
    end
  end

  // Shift register; new bits enter at the bottom so the first bit ends on top.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_r <= '0;
    end else if (shift_en) begin
      shift_r <= {shift_r[WORD_W-2:0], sdata_s};
    end
  end

  // The load edge latches the word into the addressed mode register, power-down or not.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_mode_r <= pso_pkg::MODE_RST;
      aux_mode_r  <= pso_pkg::MODE_RST;
      word_r      <= '0;
    end else if (load_en) begin
      word_r <= shift_r;
      if (word_addr == pso_pkg::ADDR_MAIN) begin
        main_mode_r <= pso_pkg::pso_mode_t'(word_mode);
      end
      if (word_addr == pso_pkg::ADDR_AUX) begin
        aux_mode_r <= pso_pkg::pso_mode_t'(word_mode);
      end
    end
  end

  // Maps the four select bits onto one pin function.
  function automatic pso_pkg::pso_func_t pso_decode(input logic m_hi, input logic a_hi,
                                                    input logic m_lo, input logic a_lo);
    pso_pkg::pso_func_t f;
    f = pso_pkg::F_DIS;
    case ({m_hi, a_hi})
      2'b00: begin
        f = m_lo ? (a_lo ? pso_pkg::F_LD_BOTH : pso_pkg::F_LD_MAIN)
                 : (a_lo ? pso_pkg::F_LD_AUX : pso_pkg::F_DIS);
      end
      2'b01: begin
        f = a_lo ? pso_pkg::F_FB_AUX : pso_pkg::F_REF_AUX;
      end
      2'b10: begin
        f = a_lo ? pso_pkg::F_FB_MAIN : pso_pkg::F_REF_MAIN;
      end
      2'b11: begin
        f = m_lo ? (a_lo ? pso_pkg::F_RST_ALL : pso_pkg::F_RST_MAIN)
                 : (a_lo ? pso_pkg::F_RST_AUX : pso_pkg::F_FAST);
      end
      default: begin
        f = pso_pkg::F_DIS;
      end
    endcase
    return f;
  endfunction

  // Function select and the per-loop reset demands.
  pso_pkg::pso_func_t func;
  assign func = pso_decode(main_mode_r.sel_hi, aux_mode_r.sel_hi,
                           main_mode_r.sel_lo, aux_mode_r.sel_lo);
  wire rst_main = (func == pso_pkg::F_RST_MAIN) | (func == pso_pkg::F_RST_ALL);
  wire rst_aux  = (func == pso_pkg::F_RST_AUX) | (func == pso_pkg::F_RST_ALL);
  wire fast_nxt = (func == pso_pkg::F_FAST) & main_gain_r;

  // Lock qualification for the selected lock-detect mode.
  wire is_ld = (func == pso_pkg::F_LD_AUX) | (func == pso_pkg::F_LD_MAIN) |
               (func == pso_pkg::F_LD_BOTH);
  wire ld_ok = (func == pso_pkg::F_LD_AUX)  ? alock_s :
               (func == pso_pkg::F_LD_MAIN) ? mlock_s :
               (mlock_s & alock_s);

  // Pin drive: open drain pulls low, divider views are push-pull.
  wire drv_div = (func == pso_pkg::F_REF_AUX) | (func == pso_pkg::F_REF_MAIN) |
                 (func == pso_pkg::F_FB_AUX) | (func == pso_pkg::F_FB_MAIN);
  wire div_val = (func == pso_pkg::F_REF_AUX)  ? in_s[pso_pkg::IN_AREF] :
                 (func == pso_pkg::F_REF_MAIN) ? in_s[pso_pkg::IN_MREF] :
                 (func == pso_pkg::F_FB_AUX)   ? in_s[pso_pkg::IN_AFB] :
                 in_s[pso_pkg::IN_MFB];
  wire pin_oe_nxt = drv_div | (is_ld & ~ld_ok) | fast_nxt;
  wire pin_o_nxt  = drv_div & div_val;

  // Gain changes take effect only while no pump pulse is in flight.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_gain_r <= 1'b0;
      aux_gain_r  <= 1'b0;
    end else if (!cpbusy_s) begin
      main_gain_r <= main_mode_r.cp_4x;
      aux_gain_r  <= aux_mode_r.cp_4x;
    end
  end

  // Registered pin, reset and pump controls; one reset drives both counters of a loop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_out_pin_o   <= 1'b0;
      status_out_pin_oe  <= 1'b0;
      main_ref_cnt_rst_o <= 1'b0;
      main_fb_cnt_rst_o  <= 1'b0;
      aux_ref_cnt_rst_o  <= 1'b0;
      aux_fb_cnt_rst_o   <= 1'b0;
      main_cp_hiz_o      <= 1'b0;
      aux_cp_hiz_o       <= 1'b0;
      fast_r             <= 1'b0;
      ld_ok_r            <= 1'b0;
    end else begin
      status_out_pin_o   <= pin_o_nxt;
      status_out_pin_oe  <= pin_oe_nxt;
      main_ref_cnt_rst_o <= rst_main;
      main_fb_cnt_rst_o  <= rst_main;
      aux_ref_cnt_rst_o  <= rst_aux;
      aux_fb_cnt_rst_o   <= rst_aux;
      main_cp_hiz_o      <= rst_main | main_mode_r.cp_tri;
      aux_cp_hiz_o       <= rst_aux | aux_mode_r.cp_tri;
      fast_r             <= fast_nxt;
      ld_ok_r            <= is_ld & ld_ok;
    end
  end

  // Pump gain, polarity and fast state outputs.
  assign main_cp_gain_4x_o = main_gain_r;
  assign aux_cp_gain_4x_o  = aux_gain_r;
  assign main_pd_pol_o     = main_mode_r.pd_pol;
  assign aux_pd_pol_o      = aux_mode_r.pd_pol;
  assign fast_acq_o        = fast_r;

  // APB decode; the slave answers in the first access cycle.
  wire apb_setup = psel & ~penable;
  wire apb_acc   = psel & penable;
  wire hit_ctrl  = (paddr == pso_pkg::OFS_CTRL);
  wire hit_mode  = (paddr == pso_pkg::OFS_MODE);
  wire hit_stat  = (paddr == pso_pkg::OFS_STATUS);
  wire hit_mask  = (paddr == pso_pkg::OFS_MASK);
  wire hit_word  = (paddr == pso_pkg::OFS_WORD);
  wire hit_any   = hit_ctrl | hit_mode | hit_stat | hit_mask | hit_word;
  wire wr_en     = apb_acc & pwrite & hit_any;
  wire [31:0] mode_view = (32'(func) << pso_pkg::MODE_FUNC_LSB) |
                          (32'(main_mode_r) << pso_pkg::MODE_MAIN_LSB) | 32'(aux_mode_r);
  wire [31:0] rd_mux = hit_ctrl ? 32'(ctrl_accept_r) :
                       hit_mode ? mode_view :
                       hit_stat ? 32'(status_r) :
                       hit_mask ? 32'(mask_r) :
                       hit_word ? 32'(word_r) : 32'h0000_0000;
  assign pready  = 1'b1;
  assign pslverr = apb_acc & ~hit_any;
  assign prdata  = prdata_r;

  // Events: word loaded, fast entry, fast exit, lock lost; set wins over clear.
  wire [pso_pkg::EV_W-1:0] ev_set = {ld_ok_r & ~(is_ld & ld_ok), fast_r & ~fast_nxt,
                                     fast_nxt & ~fast_r, load_en};
  wire [pso_pkg::EV_W-1:0] ev_clr = (wr_en & hit_stat) ? pwdata[pso_pkg::EV_W-1:0] : '0;
  assign status_nxt = (status_r & ~ev_clr) | ev_set;
  assign irq_o      = |(status_r & mask_r);

  // Register file and read data capture in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_accept_r <= pso_pkg::CTRL_RST;
      mask_r        <= pso_pkg::MASK_RST;
      status_r      <= '0;
      prdata_r      <= 32'h0000_0000;
    end else begin
      status_r <= status_nxt;
      if (wr_en && hit_ctrl) begin
        ctrl_accept_r <= pwdata[pso_pkg::CTRL_ACCEPT];
      end
      if (wr_en && hit_mask) begin
        mask_r <= pwdata[pso_pkg::EV_W-1:0];
      end
      if (apb_setup) begin
        prdata_r <= rd_mux;
      end
    end
  end

  // Checks on the decoded outputs.
  property p_disabled;
    @(posedge pclk) disable iff (!presetn)
    (func == pso_pkg::F_DIS) |=> !status_out_pin_oe;
  endproperty
  a_disabled: assert property (p_disabled) else $error("Disabled pin is driven.");

  property p_ref_main;
    @(posedge pclk) disable iff (!presetn)
    (func == pso_pkg::F_REF_MAIN) |=>
      (status_out_pin_oe && status_out_pin_o == $past(in_s[pso_pkg::IN_MREF]));
  endproperty
  a_ref_main: assert property (p_ref_main) else $error("Reference view wrong.");

  property p_fb_aux;
    @(posedge pclk) disable iff (!presetn)
    (func == pso_pkg::F_FB_AUX) |=>
      (status_out_pin_oe && status_out_pin_o == $past(in_s[pso_pkg::IN_AFB]));
  endproperty
  a_fb_aux: assert property (p_fb_aux) else $error("Feedback view wrong.");

  property p_fast_pin;
    @(posedge pclk) disable iff (!presetn)
    fast_acq_o |-> (status_out_pin_oe && !status_out_pin_o && $past(main_cp_gain_4x_o));
  endproperty
  a_fast_pin: assert property (p_fast_pin) else $error("Fast switch not pulling low.");

  property p_rst_aux;
    @(posedge pclk) disable iff (!presetn)
    (func == pso_pkg::F_RST_AUX) |=> (aux_ref_cnt_rst_o && aux_cp_hiz_o && !main_fb_cnt_rst_o);
  endproperty
  a_rst_aux: assert property (p_rst_aux) else $error("Aux reset missing.");

  property p_rst_main;
    @(posedge pclk) disable iff (!presetn)
    (func == pso_pkg::F_RST_MAIN) |=> (main_fb_cnt_rst_o && main_cp_hiz_o && !aux_ref_cnt_rst_o);
  endproperty
  a_rst_main: assert property (p_rst_main) else $error("Main reset missing.");

  property p_rst_all;
    @(posedge pclk) disable iff (!presetn)
    (func == pso_pkg::F_RST_ALL) |=> (main_ref_cnt_rst_o && aux_fb_cnt_rst_o &&
                                     main_cp_hiz_o && aux_cp_hiz_o);
  endproperty
  a_rst_all: assert property (p_rst_all) else $error("Full reset missing.");

  property p_ld_locked;
    @(posedge pclk) disable iff (!presetn)
    ((func == pso_pkg::F_LD_MAIN) && mlock_s) |=> !status_out_pin_oe;
  endproperty
  a_ld_locked: assert property (p_ld_locked) else $error("Locked pin pulled low.");

  property p_ld_both;
    @(posedge pclk) disable iff (!presetn)
    ((func == pso_pkg::F_LD_BOTH) && !(mlock_s && alock_s)) |=>
      (status_out_pin_oe && !status_out_pin_o);
  endproperty
  a_ld_both: assert property (p_ld_both) else $error("Combined lock shown wrongly.");

  property p_fast_on;
    @(posedge pclk) disable iff (!presetn)
    ((func == pso_pkg::F_FAST) && main_gain_r) |=> fast_acq_o;
  endproperty
  a_fast_on: assert property (p_fast_on) else $error("Fast acquisition not entered.");

  property p_align;
    @(posedge pclk) disable iff (!presetn)
    (main_ref_cnt_rst_o == main_fb_cnt_rst_o) && (aux_ref_cnt_rst_o == aux_fb_cnt_rst_o);
  endproperty
  a_align: assert property (p_align) else $error("Counters leave reset apart.");

  property p_shift;
    @(posedge pclk) disable iff (!presetn)
    shift_en |=> (shift_r[0] == $past(sdata_s));
  endproperty
  a_shift: assert property (p_shift) else $error("Serial bit not captured.");

  property p_gain_sync;
    @(posedge pclk) disable iff (!presetn)
    (main_gain_r != $past(main_gain_r)) |-> ($past(cpbusy_s) == 1'b0);
  endproperty
  a_gain_sync: assert property (p_gain_sync) else $error("Gain changed mid pulse.");

endmodule // pso_top

// File: test/pso_host.sv
// Purpose: Behavioural host that shifts mode words into the serial loader.
// Assumes: Serial clock period of 125 ns, clock idle low between frames.
// Notes:   Outside frames the data line shows the inverse of the last bit.
`timescale 1ns/100ps
module pso_host (
  output logic ser_clk,  // Serial clock.
  output logic ser_data, // Serial data.
  output logic ser_le    // Load enable.
);
  // Idle levels at time zero; load enable rests high between words.
  initial begin
    ser_clk  = 1'b0;
    ser_data = 1'b0;
    ser_le   = 1'b1;
  end

  // Shifts one word with load low, then raises load once to latch it.
  task automatic send(input logic [21:0] w);
    ser_le = 1'b0;
    for (int i = 21; i >= 0; i--) begin
      ser_data = w[i];
      #31.2 ser_clk = 1'b1;
      #62.5 ser_clk = 1'b0;
      #31.3;
    end
    ser_data = ~w[0];
    #62.5 ser_le = 1'b1;
    #62.5;
  endtask
endmodule // pso_host

// File: test/pll_status_output_select_bench.sv
// Purpose: Self-checking bench for the status pin selector and its registers.
// Assumes: Outputs settle within eight cycles after a load edge.
// Notes:   Divider inputs take two distinct patterns so each view is told apart from its loop's other view and the other loop's same view.
`timescale 1ns/100ps
module pll_status_output_select_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_o, e;
  logic [11:0] paddr, f;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  dv;
  logic        sck, sda, sle, mlk, alk, busy, po, poe, mh, ah, ml, al;
  logic        mrr, mfr, arr, afr, mhz, ahz, mg4, ag4, mpl, apl, fast;
  int          n_mismatch = 0;
  int          checked = 0;

  pso_host host (.ser_clk(sck), .ser_data(sda), .ser_le(sle));

  pso_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_o(irq_o), .ser_clk_i(sck), .ser_data_i(sda), .ser_le_i(sle),
    .main_lock_i(mlk), .aux_lock_i(alk), .main_ref_div_i(dv[3]), .aux_ref_div_i(dv[2]),
    .main_fb_div_i(dv[1]), .aux_fb_div_i(dv[0]), .main_cp_busy_i(busy),
    .status_out_pin_o(po), .status_out_pin_oe(poe), .main_ref_cnt_rst_o(mrr),
    .main_fb_cnt_rst_o(mfr), .aux_ref_cnt_rst_o(arr), .aux_fb_cnt_rst_o(afr),
    .main_cp_hiz_o(mhz), .aux_cp_hiz_o(ahz), .main_cp_gain_4x_o(mg4),
    .aux_cp_gain_4x_o(ag4), .main_pd_pol_o(mpl), .aux_pd_pol_o(apl), .fast_acq_o(fast));

  // Clock toggles every half period of 5 ns.
  always #5 pclk = ~pclk;

  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
      n_mismatch++;
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  // Lets a latched word reach the outputs.
  task automatic settle();
    repeat (8) @(posedge pclk);
    #1;
  endtask

  // Expected one-hot pin function from the four select bits.
  function automatic logic [11:0] efn(input logic mh, ah, ml, al);
    if (!mh && !ah) return 12'h001 << {ml, al};
    if (ah && !mh) return al ? 12'h040 : 12'h010;
    if (mh && !ah) return al ? 12'h080 : 12'h020;
    return 12'h100 << {ml, al};
  endfunction

  // Prints the verdict and ends the run.
  task automatic wrap_up();
    if (n_mismatch == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    #400000;
    n_mismatch++;
    wrap_up();
  end

  // Main sequence: reset, registers, all selections, interrupt, fast and lock cases.
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, busy, alk} = '0;
    mlk = 1'b1;
    dv = 4'h6;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h00c, 0);
    chk("mask", 0, q);
    apb(0, 12'h000, 0);
    chk("ctrl", 1, q);
    apb(0, 12'h020, 0);
    chk("unmapped", 0, q);
    chk("slverr", 1, e);
    for (int k = 0; k < 16; k++) begin
      {mh, ah, ml, al} = k[3:0];
      host.send({ah, al, 3'b001, 15'h0000, 2'h0});
      host.send({mh, ml, 3'b000, 15'h0000, 2'h2});
      settle();
      f = efn(mh, ah, ml, al);
      apb(1, 12'h004, 0);
      apb(0, 12'h004, 0);
      chk("mode", {4'h0, f, 6'h00, mh, ml, 3'b000, ah, al, 3'b001}, q);
      chk("pin", {|(f & 12'h0fa), |(f & 12'h090)}, {poe, poe & po});
      chk("rst", {{2{|(f & 12'hc00)}}, {2{|(f & 12'ha00)}}, |(f & 12'hc00), |(f & 12'ha00),
          1'b1}, {mrr, mfr, arr, afr, mhz, ahz, apl});
      @(posedge pclk);
      dv <= 4'h9;
      settle();
      chk("pin_inv", |(f & 12'h060), poe & po);
      @(posedge pclk);
      dv <= 4'h6;
      settle();
    end
    apb(1, 12'h00c, 1);
    chk("irq_on", 1, irq_o);
    apb(1, 12'h008, 1);
    chk("irq_off", 0, irq_o);
    apb(0, 12'h008, 0);
    chk("loaded", 0, q[0]);
    host.send({5'b10010, 15'h0000, 2'h0});
    host.send({5'b10011, 15'h0000, 2'h2});
    settle();
    chk("fast", 6'b111011, {fast, mg4, poe, po, ag4, mpl});
    @(posedge pclk);
    busy <= 1'b1;
    host.send({5'b10000, 15'h0000, 2'h2});
    settle();
    chk("gain_hold", 2'b11, {fast, mg4});
    @(posedge pclk);
    busy <= 1'b0;
    settle();
    chk("gain_off", 3'b000, {fast, mg4, poe});
    apb(0, 12'h008, 0);
    chk("fast_ev", 2'b11, q[2:1]);
    apb(1, 12'h008, 32'h0000_000f);
    host.send({5'b01100, 15'h0000, 2'h0});
    host.send({5'b01000, 15'h0000, 2'h2});
    @(posedge pclk);
    alk <= 1'b1;
    settle();
    chk("both_lock", 3'b010, {poe, ahz, mhz});
    @(posedge pclk);
    mlk <= 1'b0;
    settle();
    chk("main_lost", 2'b10, {poe, po});
    apb(0, 12'h008, 0);
    chk("lost_ev", 1, q[3]);
    wrap_up();
  end
endmodule // pll_status_output_select_bench
